// file: hdl/expanded_memory_map_config.sv
// Configuration registers and address routing for the expanded-memory page mapper.
// Assumes host I/O and memory cycle inputs are synchronous to i_clk, one cycle each.
//
// Notes on behaviour
// - Upper bit 7 gates window translation; backfill translates without it.
// - Upper bit 6 enables backfill translation of 256K-640K with a pointer above 09h.
// - Pointer write 04h-09h clears backfill enable.
// - Upper bit 5 always reads one.
// - Remap moves C and E windows into A and B; D stays.
// - Upper bits 3-0 enable E or B windows.
// - Lower bits 3-0 enable C or A windows.
// - Lower bits 7-4 enable D windows always.
// - Pointer zero starts no DRAM cycle.
// - Low pointer routes board, slot, nothing.
// - Low pointer keeps page translation working.
// - Pointer 0Ah-0Fh behaves as 10h.
// - High pointer routes low memory to board.
// - Translation uses board RAM above pointer.
// - Active windows override shadow, get translated.
// - Without paging, shadow controls route upper 384K.
// - Pointer to FDFFFFh slot, above is ROM.
// - Registers reached through index port E8h.
`include "ems_map_defines.svh"
`default_nettype none
module expanded_memory_map_config (
    // Clock and reset.
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_n,
    // Host I/O cycle.
    input  wire logic                 i_io_wr,
    input  wire logic                 i_io_rd,
    input  wire logic [7:0]           i_io_addr,
    input  wire logic [7:0]           i_io_wdata,
    input  wire logic [7:0]           i_cfg_data_port,
    output logic      [7:0]           o_io_rdata,
    // Slot pointer update from the memory controller.
    input  wire logic                 i_ptr_wr,
    input  wire logic [7:0]           i_ptr_wdata,
    // Shadow controls, two bits per 64K segment A, B, C, D, and one pair shared by E and F.
    input  wire logic [1:0]           i_shadow_ctrl_seg_ab [2],
    input  wire logic [1:0]           i_shadow_ctrl_seg_c,
    input  wire logic [1:0]           i_shadow_ctrl_seg_d,
    input  wire logic [1:0]           i_shadow_ctrl_seg_ef,
    // CPU memory cycle.
    input  wire logic                 i_mem_req,
    input  wire logic                 i_mem_wr,
    input  wire logic [23:0]          i_mem_addr,
    output ems_map_pkg::dest_t        o_dest,
    output logic                      o_dram_start,
    output logic      [3:0]           o_page_index,
    // Configuration state seen by the page registers.
    output logic                      o_page_map_global_enable,
    output logic                      o_backfill_enable,
    output logic                      o_window_remap_select,
    output logic      [11:0]          o_window_enables,
    output logic      [7:0]           o_slot_boundary_pointer
);
    import ems_map_pkg::*;

    logic [7:0]  ems_ctrl_upper_windows_q;
    logic [7:0]  ems_lower_window_enables_q;
    logic [5:0]  index_q;
    logic [7:0]  ptr_q;
    logic [7:0]  eff_ptr;
    logic [23:0] ptr_addr;
    logic        hit_index;
    logic        hit_data;
    logic        ptr_low_wr;
    logic        win_hit;
    logic [3:0]  win_idx;
    logic [11:0] win_en;
    logic [1:0]  shadow_bits;
    dest_t       dest_d;

    // Pointer in the low band; shared by the clear logic and the routing.
    function automatic logic ptr_is_low(input logic [7:0] p);
        ptr_is_low = (p >= `PTR_LOW_MIN) && (p <= `PTR_LOW_MAX);
    endfunction

    assign hit_index  = (i_io_addr == `CFG_INDEX_PORT);
    assign hit_data   = (i_io_addr == i_cfg_data_port);
    assign ptr_low_wr = i_ptr_wr && ptr_is_low(i_ptr_wdata);

    // Index register selects which configuration register the data port reaches.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            index_q <= 6'h00;
        end else if (i_io_wr && hit_index) begin
            index_q <= i_io_wdata[5:0];
        end
    end

    // Upper register; the pointer clear wins over a same-cycle software write
    // so that backfill can never stay on above a low pointer.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ems_ctrl_upper_windows_q <= `UPPER_RESET;
        end else begin
            if (i_io_wr && hit_data && index_q == `CFG_IDX_UPPER) begin
                ems_ctrl_upper_windows_q <= {i_io_wdata[7:6], 1'b1, i_io_wdata[4:0]};
            end
            if (ptr_low_wr) begin
                ems_ctrl_upper_windows_q[`BIT_BACKFILL_EN] <= 1'b0;
            end
        end
    end

    // Lower register stores all eight window enables.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ems_lower_window_enables_q <= `LOWER_RESET;
        end else if (i_io_wr && hit_data && index_q == `CFG_IDX_LOWER) begin
            ems_lower_window_enables_q <= i_io_wdata;
        end
    end

    // Slot pointer copy held locally for routing.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ptr_q <= `PTR_SRAM;
        end else if (i_ptr_wr) begin
            ptr_q <= i_ptr_wdata;
        end
    end

    // Read-back; unselected addresses return zero.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_io_rdata <= 8'h00;
        end else if (i_io_rd && hit_index) begin
            o_io_rdata <= {2'b00, index_q};
        end else if (i_io_rd && hit_data && index_q == `CFG_IDX_UPPER) begin
            o_io_rdata <= ems_ctrl_upper_windows_q | 8'h20;
        end else if (i_io_rd && hit_data && index_q == `CFG_IDX_LOWER) begin
            o_io_rdata <= ems_lower_window_enables_q;
        end else if (i_io_rd) begin
            o_io_rdata <= 8'h00;
        end
    end

    // Window enables in window order 0..11: C/A, D, B/E.
    assign win_en = {ems_ctrl_upper_windows_q[3:0], ems_lower_window_enables_q};

    // Decode which 16K window the address falls in, honouring the remap bit.
    always_comb begin
        win_hit = 1'b0;
        win_idx = 4'h0;
        if (i_mem_addr[23:16] == 8'h0d) begin
            win_hit = 1'b1;
            win_idx = {2'b01, i_mem_addr[15:14]};
        end else if (i_mem_addr[23:16] ==
                     (ems_ctrl_upper_windows_q[`BIT_REMAP] ? 8'h0a : 8'h0c)) begin
            win_hit = 1'b1;
            win_idx = {2'b00, i_mem_addr[15:14]};
        end else if (i_mem_addr[23:16] ==
                     (ems_ctrl_upper_windows_q[`BIT_REMAP] ? 8'h0b : 8'h0e)) begin
            win_hit = 1'b1;
            win_idx = {2'b10, i_mem_addr[15:14]};
        end
    end

    // Pointer values 0Ah-0Fh route as 10h; the pointer counts 64K units.
    assign eff_ptr  = (ptr_q > `PTR_LOW_MAX && ptr_q <= `PTR_MID_MAX) ?
                      `PTR_MID_EQUIV : ptr_q;
    assign ptr_addr = {eff_ptr, 16'h0000};

    // Shadow control pair for the upper 384K segment the address falls in.
    always_comb begin
        case (i_mem_addr[19:16])
            4'ha:    shadow_bits = i_shadow_ctrl_seg_ab[0];
            4'hb:    shadow_bits = i_shadow_ctrl_seg_ab[1];
            4'hc:    shadow_bits = i_shadow_ctrl_seg_c;
            4'hd:    shadow_bits = i_shadow_ctrl_seg_d;
            default: shadow_bits = i_shadow_ctrl_seg_ef;
        endcase
    end

    // Routing of one CPU memory cycle.
    always_comb begin
        dest_d = DEST_NONE;
        if (ems_ctrl_upper_windows_q[`BIT_GLOBAL_EN] && win_hit && win_en[win_idx]) begin
            dest_d = DEST_XLATE;
        end else if (i_mem_addr >= `ADDR_ROM_LO) begin
            dest_d = DEST_ROM;
        end else if (i_mem_addr >= `ADDR_640K && i_mem_addr < `ADDR_1M) begin
            // Shadow controls decide the upper 384K; E and F default to ROM.
            case (shadow_bits)
                2'b11:   dest_d = DEST_BOARD;
                2'b10:   dest_d = i_mem_wr ? DEST_SLOT : DEST_BOARD;
                2'b01:   dest_d = i_mem_wr ? DEST_BOARD :
                                  (i_mem_addr[19:17] == 3'b111 ? DEST_ROM : DEST_SLOT);
                default: dest_d = (i_mem_addr[19:17] == 3'b111) ? DEST_ROM : DEST_SLOT;
            endcase
        end else if (ptr_q == `PTR_SRAM) begin
            dest_d = DEST_SLOT;
        end else if (ptr_is_low(eff_ptr)) begin
            dest_d = (i_mem_addr < ptr_addr) ? DEST_BOARD : DEST_SLOT;
        end else if (i_mem_addr < `ADDR_256K) begin
            dest_d = DEST_BOARD;
        end else if (i_mem_addr < `ADDR_640K) begin
            dest_d = ems_ctrl_upper_windows_q[`BIT_BACKFILL_EN] ? DEST_XLATE : DEST_BOARD;
        end else if (i_mem_addr < ptr_addr) begin
            dest_d = DEST_BOARD;
        end else begin
            dest_d = DEST_SLOT;
        end
    end

    // Registered routing result; SRAM mode never asserts a DRAM start.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_dest       <= DEST_NONE;
            o_dram_start <= 1'b0;
            o_page_index <= 4'h0;
        end else begin
            o_dest       <= i_mem_req ? dest_d : DEST_NONE;
            o_dram_start <= i_mem_req && ptr_q != `PTR_SRAM &&
                            (dest_d == DEST_BOARD || dest_d == DEST_XLATE);
            o_page_index <= win_idx;
        end
    end

    // Configuration copies for the page registers.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_page_map_global_enable <= 1'b0;
            o_backfill_enable        <= 1'b0;
            o_window_remap_select    <= 1'b0;
            o_window_enables         <= 12'h000;
            o_slot_boundary_pointer  <= 8'h00;
        end else begin
            o_page_map_global_enable <= ems_ctrl_upper_windows_q[`BIT_GLOBAL_EN];
            o_backfill_enable        <= ems_ctrl_upper_windows_q[`BIT_BACKFILL_EN];
            o_window_remap_select    <= ems_ctrl_upper_windows_q[`BIT_REMAP];
            o_window_enables         <= win_en;
            o_slot_boundary_pointer  <= ptr_q;
        end
    end

    // Bit 5 is forced on every write path, so software can never see it low.
    upper_bit5_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        ems_ctrl_upper_windows_q[`BIT_FIXED_ONE])
        else $error("fixed bit lost");
    // A low pointer write must win over any same-cycle software write of bit 6.
    backfill_clr_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        ptr_low_wr |=> !ems_ctrl_upper_windows_q[`BIT_BACKFILL_EN])
        else $error("backfill not cleared");
    // With the pointer at zero no DRAM start may leave the block.
    sram_nodram_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (ptr_q == `PTR_SRAM && !i_ptr_wr) |=> !o_dram_start)
        else $error("dram started in sram mode");
    // With both enables off nothing may be translated.
    xlate_gate_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_mem_req && !ems_ctrl_upper_windows_q[`BIT_GLOBAL_EN]
         && !ems_ctrl_upper_windows_q[`BIT_BACKFILL_EN]) |=> o_dest != DEST_XLATE)
        else $error("translation without enable");
    // The top 128K always selects ROM.
    rom_top_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_mem_req && i_mem_addr >= `ADDR_ROM_LO) |=> o_dest == DEST_ROM)
        else $error("top not routed to rom");
    // Above the low band the first 256K is always board memory.
    low_board_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_mem_req && ptr_q > `PTR_LOW_MAX && i_mem_addr < `ADDR_256K)
        |=> o_dest == DEST_BOARD) else $error("low memory not on board");
    // D windows translate whatever the remap bit says.
    d_window_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_mem_req && ems_ctrl_upper_windows_q[`BIT_GLOBAL_EN]
         && i_mem_addr[23:16] == 8'h0d && ems_lower_window_enables_q[4 + i_mem_addr[15:14]])
        |=> o_dest == DEST_XLATE) else $error("d window not translated");
    // Every bit of the lower register is stored as written.
    lower_store_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_io_wr && hit_data && index_q == `CFG_IDX_LOWER)
        |=> ems_lower_window_enables_q == $past(i_io_wdata))
        else $error("lower write lost");
    // Pointer values just below 1M route like the 1M pointer.
    mid_equiv_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (ptr_q > `PTR_LOW_MAX && ptr_q <= `PTR_MID_MAX) |-> eff_ptr == `PTR_MID_EQUIV)
        else $error("mid pointer not equivalent");
    // The index port keeps the six low bits of what was written.
    index_store_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_io_wr && hit_index) |=> index_q == 6'($past(i_io_wdata)))
        else $error("index write lost");
    // Upper writes store all bits but bit 5, unless a pointer clear collides.
    upper_store_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_io_wr && hit_data && index_q == `CFG_IDX_UPPER && !ptr_low_wr)
        |=> ems_ctrl_upper_windows_q == ($past(i_io_wdata) | 8'h20))
        else $error("upper write lost");
    // The page registers see the backfill enable one cycle later.
    backfill_copy_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        ems_ctrl_upper_windows_q[`BIT_BACKFILL_EN] |=> o_backfill_enable)
        else $error("backfill enable not passed on");
    // Remapped upper enables cover the B segment.
    remap_b_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_mem_req && ems_ctrl_upper_windows_q[`BIT_GLOBAL_EN]
         && ems_ctrl_upper_windows_q[`BIT_REMAP] && i_mem_addr[23:16] == 8'h0b
         && ems_ctrl_upper_windows_q[i_mem_addr[15:14]]) |=> o_dest == DEST_XLATE)
        else $error("b window not translated");
    // Remapped lower enables cover the A segment.
    remap_a_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_mem_req && ems_ctrl_upper_windows_q[`BIT_GLOBAL_EN]
         && ems_ctrl_upper_windows_q[`BIT_REMAP] && i_mem_addr[23:16] == 8'h0a
         && ems_lower_window_enables_q[i_mem_addr[15:14]]) |=> o_dest == DEST_XLATE)
        else $error("a window not translated");
    // Without remap the upper enables cover the E segment.
    e_window_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_mem_req && ems_ctrl_upper_windows_q[`BIT_GLOBAL_EN]
         && !ems_ctrl_upper_windows_q[`BIT_REMAP] && i_mem_addr[23:16] == 8'h0e
         && ems_ctrl_upper_windows_q[i_mem_addr[15:14]]) |=> o_dest == DEST_XLATE)
        else $error("e window not translated");
    // A low pointer sends memory below it to the board.
    low_ptr_board_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_mem_req && ptr_is_low(ptr_q) && i_mem_addr < {ptr_q, 16'h0000})
        |=> o_dest == DEST_BOARD) else $error("below low pointer not on board");
    // A low pointer sends extended memory to the slots.
    low_ptr_slot_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_mem_req && ptr_is_low(ptr_q) && i_mem_addr >= `ADDR_1M
         && i_mem_addr < `ADDR_ROM_LO) |=> o_dest == DEST_SLOT)
        else $error("extended memory not on slot");
    // Page translation must survive a low pointer.
    low_ptr_xlate_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_mem_req && ptr_is_low(ptr_q) && ems_ctrl_upper_windows_q[`BIT_GLOBAL_EN]
         && i_mem_addr[23:16] == 8'h0d && ems_lower_window_enables_q[4 + i_mem_addr[15:14]])
        |=> o_dest == DEST_XLATE) else $error("translation lost at low pointer");
    // With backfill on and a high pointer, 256K-640K feeds the page pool.
    backfill_xlate_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_mem_req && ptr_q > `PTR_LOW_MAX && ems_ctrl_upper_windows_q[`BIT_BACKFILL_EN]
         && i_mem_addr >= `ADDR_256K && i_mem_addr < `ADDR_640K)
        |=> o_dest == DEST_XLATE) else $error("backfill range not translated");
    // Shadow code 11 keeps an unpaged C segment on the board.
    shadow_board_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_mem_req && !ems_ctrl_upper_windows_q[`BIT_GLOBAL_EN]
         && i_mem_addr[23:16] == 8'h0c && i_shadow_ctrl_seg_c == 2'b11)
        |=> o_dest == DEST_BOARD) else $error("shadow code ignored");
    // A high pointer keeps memory from 1M up to it on the board.
    high_ptr_board_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_mem_req && ptr_q > `PTR_MID_MAX && i_mem_addr >= `ADDR_1M
         && i_mem_addr < {ptr_q, 16'h0000}) |=> o_dest == DEST_BOARD)
        else $error("extended board memory lost");
    // Accesses below 256K with a pointer above the low band must start a DRAM cycle.
    dram_start_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_mem_req && ptr_q > `PTR_LOW_MAX && i_mem_addr < `ADDR_256K)
        |=> o_dram_start) else $error("dram cycle missing");
endmodule
`default_nettype wire

// file: hdl/ems_map_defines.svh
// Offsets, field positions, reset values and address limits of the page-mapping block.
// Assumes inclusion by bare name from the design file.
`ifndef EMS_MAP_DEFINES_SVH
`define EMS_MAP_DEFINES_SVH
`define CFG_INDEX_PORT      8'he8
`define CFG_IDX_UPPER       6'h0b
`define CFG_IDX_LOWER       6'h0c
`define UPPER_RESET         8'h20
`define LOWER_RESET         8'h00
`define BIT_GLOBAL_EN       7
`define BIT_BACKFILL_EN     6
`define BIT_FIXED_ONE       5
`define BIT_REMAP           4
`define PTR_SRAM            8'h00
`define PTR_LOW_MIN         8'h04
`define PTR_LOW_MAX         8'h09
`define PTR_MID_MAX         8'h0f
`define PTR_MID_EQUIV       8'h10
`define ADDR_256K           24'h040000
`define ADDR_640K           24'h0a0000
`define ADDR_1M             24'h100000
`define ADDR_WIN_LO         24'h0a0000
`define ADDR_WIN_HI         24'h0effff
`define ADDR_ROM_LO         24'hfe0000
`define PTR_UNIT_SHIFT      16
`endif

// file: hdl/ems_map_pkg.sv
// Types shared by the page-mapping configuration block.
// Assumes the defines header is on the include path.
`default_nettype none
package ems_map_pkg;
    typedef enum logic [4:0] {
        DEST_NONE  = 5'b00001,
        DEST_BOARD = 5'b00010,
        DEST_SLOT  = 5'b00100,
        DEST_ROM   = 5'b01000,
        DEST_XLATE = 5'b10000
    } dest_t;
endpackage
`default_nettype wire

// file: verification/host_cpu_model.sv
// Host CPU model that issues single memory cycles to the page mapper.
// Assumes the caller shares i_clk and waits for each cycle task to return.
`default_nettype none
module host_cpu_model (
    // Clock.
    input  wire logic        i_clk,
    // Memory cycle.
    output logic             o_req,
    output logic             o_wr,
    output logic [23:0]      o_addr
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle values before the first cycle.
    initial begin
        o_req  = 1'b0;
        o_wr   = 1'b0;
        o_addr = 24'h000000;
    end

    // One cycle of request, then the lines show the inverse so a stale address cannot pass.
    task automatic cycle(input logic [23:0] addr, input logic wr);
        @(posedge i_clk);
        o_req  <= 1'b1;
        o_wr   <= wr;
        o_addr <= addr;
        @(posedge i_clk);
        o_req  <= 1'b0;
        o_wr   <= ~wr;
        o_addr <= ~addr;
    endtask
endmodule
`default_nettype wire

// file: verification/expanded_memory_map_config_tb.sv
// Self-checking bench for the page-mapper configuration and routing block.
// Assumes the host model drives memory cycles and shadow controls stay at code 00.
`default_nettype none
module expanded_memory_map_config_tb;
    import ems_map_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0, i_rst_n = 1'b0, io_wr = 1'b0, io_rd = 1'b0, ptr_wr = 1'b0;
    logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, ptr_wdata = 8'h00, ptr_m = 8'h00, rdat;
    logic [1:0] sh_ab [2] = '{2'b00, 2'b00};
    logic mem_req, mem_wr, o_dram_start, rd_d = 1'b0, req_d = 1'b0;
    logic [23:0] mem_addr;
    dest_t o_dest;
    logic [7:0] io_q [$];
    logic [7:0] route_q [$];
    int fail_count = 0, samples_checked = 0, seed = 53970, v;

    // Free-running clock at 100 MHz.
    always #5 i_clk = ~i_clk;

    host_cpu_model i_host (.i_clk(i_clk), .o_req(mem_req), .o_wr(mem_wr), .o_addr(mem_addr));

    expanded_memory_map_config i_dut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_io_wr(io_wr), .i_io_rd(io_rd),
        .i_io_addr(io_addr), .i_io_wdata(io_wdata), .i_cfg_data_port(8'hed),
        .o_io_rdata(rdat), .i_ptr_wr(ptr_wr), .i_ptr_wdata(ptr_wdata),
        .i_shadow_ctrl_seg_ab(sh_ab), .i_shadow_ctrl_seg_c(2'b00),
        .i_shadow_ctrl_seg_d(2'b00), .i_shadow_ctrl_seg_ef(2'b00),
        .i_mem_req(mem_req), .i_mem_wr(mem_wr), .i_mem_addr(mem_addr),
        .o_dest(o_dest), .o_dram_start(o_dram_start), .o_page_index(),
        .o_page_map_global_enable(), .o_backfill_enable(), .o_window_remap_select(),
        .o_window_enables(), .o_slot_boundary_pointer());

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Answers land one cycle after the request, so they are compared at the following low phase.
    always @(posedge i_clk) begin
        rd_d  <= io_rd;
        req_d <= mem_req;
    end
    always @(negedge i_clk) begin
        if (rd_d) chk("io_rdata", io_q.pop_front(), rdat);
        if (req_d) chk("dram_start_dest", route_q.pop_front(), {2'b00, o_dram_start, o_dest});
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        io_wr    <= 1'b1;
        io_addr  <= a;
        io_wdata <= d;
        @(posedge i_clk);
        io_wr    <= 1'b0;
        io_wdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        io_q.push_back(exp);
        @(posedge i_clk);
        io_rd   <= 1'b1;
        io_addr <= a;
        @(posedge i_clk);
        io_rd   <= 1'b0;
    endtask

    task automatic ptr(input logic [7:0] d);
        ptr_m = d;
        @(posedge i_clk);
        ptr_wr    <= 1'b1;
        ptr_wdata <= d;
        @(posedge i_clk);
        ptr_wr    <= 1'b0;
    endtask

    // A DRAM cycle is expected only for board or translated targets with a nonzero pointer.
    task automatic mem(input logic [23:0] a, input dest_t d);
        logic dr;
        dr = (ptr_m != 8'h00) && (d == DEST_BOARD || d == DEST_XLATE);
        route_q.push_back({2'b00, dr, d});
        i_host.cycle(a, 1'($random(seed)));
    endtask

    task automatic finish_test;
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Watchdog well beyond the roughly 150 cycles the sequence needs.
    initial begin
        #100000;
        fail_count++;
        finish_test();
    end

    initial begin
        repeat (10) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rd(8'he8, 8'h00);
        wr(8'he8, 8'h0b);
        rd(8'hed, 8'h20);
        wr(8'he8, 8'h0c);
        rd(8'hed, 8'h00);
        v = $random(seed);
        wr(8'hed, 8'(v));
        rd(8'hed, 8'(v));
        wr(8'he8, 8'h0d);
        wr(8'hed, 8'h55);
        rd(8'hed, 8'h00);
        rd(8'h80, 8'h00);
        wr(8'he8, 8'h0b);
        wr(8'hed, 8'hdf);
        rd(8'hed, 8'hff);
        for (v = 3; v <= 10; v++) begin
            wr(8'hed, 8'hff);
            ptr(8'(v));
            rd(8'hed, (v >= 4 && v <= 9) ? 8'hbf : 8'hff);
        end
        wr(8'he8, 8'h0c);
        wr(8'hed, 8'h11);
        wr(8'he8, 8'h0b);
        wr(8'hed, 8'h80);
        ptr(8'h20);
        mem(24'h010000, DEST_BOARD);
        mem(24'h090000, DEST_BOARD);
        mem(24'h150000, DEST_BOARD);
        mem(24'h0d0000, DEST_XLATE);
        mem(24'h0c0000, DEST_XLATE);
        mem(24'h0d4000, DEST_SLOT);
        mem(24'h300000, DEST_SLOT);
        mem(24'hfe0000, DEST_ROM);
        ptr(8'h00);
        mem(24'h010000, DEST_SLOT);
        ptr(8'h05);
        mem(24'h030000, DEST_BOARD);
        mem(24'h060000, DEST_SLOT);
        mem(24'h0d0000, DEST_XLATE);
        wr(8'hed, 8'hc0);
        ptr(8'h0c);
        mem(24'h090000, DEST_XLATE);
        wr(8'hed, 8'h91);
        mem(24'h0b0000, DEST_XLATE);
        mem(24'h0a0000, DEST_XLATE);
        mem(24'h0c0000, DEST_SLOT);
        mem(24'h0d0000, DEST_XLATE);
        wr(8'hed, 8'h00);
        mem(24'h0d0000, DEST_SLOT);
        repeat (3) @(posedge i_clk);
        finish_test();
    end
endmodule
`default_nettype wire
